// ---- shared/pwm_pkg.sv ----
// Purpose: constants, field layouts and carriers for the ten-channel counter pwm/fm generator
// Assumes: pclk at 25 MHz, apb slave with 32-bit data, 16-bit byte address
// Notes: registers sit in a 256-byte window, one 16-byte slot per channel plus a global slot
//
// How it works
// - ten independent channels in two groups of five, one function each.
// - each channel picks a 1 MHz, 100 kHz, 10 kHz, 1 kHz or 100 Hz timebase.
// - pulse-width mode keeps the period fixed; frequency is base over period count.
// - pulse-width mode starts from an initial duty; host writes replace it.
// - toggle-high gives high first for the duty share, low otherwise inverted.
// - host arms with 1 and disarms with 0; waves run only while armed.
// - each channel leaves reset armed or disarmed per its initial arm setting.
// - frequency mode keeps duty fixed while the frequency follows the host factor.
// - frequency mode starts from an initial period; host writes replace it.
// - frequency-mode duty stays unchanged while running, whatever updates come.
// - register window starts at a switch-set base; channels addressed relative to it.
package pwm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int TB1_HZ = 1_000_000;
    localparam int PRE_DIV = CLK_HZ / TB1_HZ;
    localparam int DECADE = 10;
    localparam logic [4:0] PRE_LAST = 5'(PRE_DIV - 1);
    localparam logic [3:0] DEC_LAST = 4'(DECADE - 1);
    localparam int NUM_SRC = 5;

    ////////////////////////////////////////////////////////////////////////////
    // channel bank
    localparam int NUM_CHAN = 10;
    localparam int GROUP_SIZE = 5;
    localparam logic [15:0] PERIOD_MIN = 16'h0002;

    ////////////////////////////////////////////////////////////////////////////
    // address map: paddr[15:8] window, [7:4] slot, [3:0] byte offset
    localparam logic [3:0] NUM_CHAN_SLOT = 4'hA;
    localparam logic [3:0] GLOBAL_SLOT = 4'hF;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_PERIOD = 4'h4;
    localparam logic [3:0] OFS_DUTY = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;
    localparam logic [3:0] OFS_ARM_SET = 4'h0;
    localparam logic [3:0] OFS_ARM_CLR = 4'h4;
    localparam logic [3:0] OFS_SUMMARY = 4'h8;

    // ctrl fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_TOGGLE_BIT = 1;
    localparam int CTRL_ARM_BIT = 2;
    localparam int CTRL_BASE_LSB = 4;
    // status fields
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_WAVE_BIT = 16;
    localparam int STAT_ARMED_BIT = 17;
    localparam int STAT_PEND_BIT = 18;
    // summary fields
    localparam int SUM_ARMED_LSB = 0;
    localparam int SUM_WAVE_LSB = 16;

    ////////////////////////////////////////////////////////////////////////////
    // types and reset values
    typedef enum logic [0:0] {
        MODE_PULSE_WIDTH = 1'b0,
        frequency_mode = 1'b1
    } chan_mode_t;

    typedef struct packed {
        chan_mode_t mode;
        logic toggle_high;
        logic armed;
        logic [2:0] base_sel;
        logic [15:0] period;
        logic [15:0] duty;
    } chan_cfg_t;

    typedef struct packed {
        logic pending;
        logic wave;
        logic [15:0] count;
    } chan_stat_t;

    localparam chan_mode_t INIT_MODE = MODE_PULSE_WIDTH;
    localparam logic INIT_TOGGLE = 1'b1;
    localparam logic [9:0] INIT_ARM = 10'h3FF;
    localparam logic [2:0] INIT_BASE = 3'h1;
    localparam logic [15:0] INIT_PERIOD = 16'h000A;
    localparam logic [15:0] INIT_DUTY = 16'h4000;

endpackage

// ---- src/counter_channel.sv ----
// Purpose: one square-wave channel, pulse-width or frequency mode
// Assumes: tick is a one-cycle enable at the chosen timebase
// Notes: period and high count are shadowed and reloaded only at a period boundary or while disarmed
`timescale 1ns/1ps
module counter_channel (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // timebase and configuration
    input wire logic tick,
    input wire pwm_pkg::chan_cfg_t cfg,
    // results
    output logic wave,
    output pwm_pkg::chan_stat_t stat
);

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_ACTIVE = 2'b01,
        CH_REST = 2'b11
    } ch_state_t;

    typedef struct packed {
        ch_state_t st;
        logic [15:0] cnt;
        logic [15:0] per_sh;
        logic [15:0] high_sh;
        logic wave;
    } ch_t;

    ch_t r, n;
    logic [15:0] per_eff;
    logic [31:0] prod;
    logic [15:0] high_new;
    logic [15:0] cnt_inc;

    // a period below two ticks cannot hold both levels, so it is raised to two
    assign per_eff = (cfg.period < pwm_pkg::PERIOD_MIN) ? pwm_pkg::PERIOD_MIN : cfg.period;
    assign prod = per_eff * cfg.duty;
    assign high_new = prod[31:16];
    assign cnt_inc = r.cnt + 16'h0001;

    // period sequencer: shadows reload when a period starts and track the config while disarmed
    always_comb begin
        n = r;
        if (!cfg.armed) begin
            n.st = CH_IDLE;
            n.cnt = 16'h0000;
            n.per_sh = per_eff;
            n.high_sh = high_new;
        end else if (tick) begin
            unique case (r.st)
                CH_IDLE: begin
                    n.cnt = 16'h0000;
                    n.per_sh = per_eff;
                    n.high_sh = high_new;
                    n.st = (high_new != 16'h0000) ? CH_ACTIVE : CH_REST;
                end
                CH_ACTIVE, CH_REST: begin
                    if (r.cnt == r.per_sh - 16'h0001) begin
                        n.cnt = 16'h0000;
                        n.per_sh = per_eff;
                        n.high_sh = high_new;
                        n.st = (high_new != 16'h0000) ? CH_ACTIVE : CH_REST;
                    end else begin
                        n.cnt = cnt_inc;
                        n.st = (cnt_inc < r.high_sh) ? CH_ACTIVE : CH_REST;
                    end
                end
            endcase
        end
        // active share at the toggle level, rest and idle at its inverse
        n.wave = (n.st == CH_ACTIVE) ? cfg.toggle_high : ~cfg.toggle_high;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{st: CH_IDLE, cnt: 16'h0000, per_sh: 16'h0000, high_sh: 16'h0000, wave: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign wave = r.wave;
    assign stat.count = r.cnt;
    assign stat.wave = r.wave;
    assign stat.pending = (per_eff != r.per_sh) || (high_new != r.high_sh);

endmodule // counter_channel

// ---- src/counter_pwm_fm_generator.sv ----
// Purpose: apb-programmed bank of ten pwm/fm square-wave channels
// Assumes: apb master per amba rules, board_window_base held steady by switches
// Notes: zero-wait slave; read data is captured in the setup cycle
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
module counter_pwm_fm_generator (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // switch-set window base
    input wire logic [7:0] board_window_base,
    // square-wave outputs, first and second group of five
    output logic [4:0] group_a_out,
    output logic [4:0] group_b_out
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        pwm_pkg::chan_cfg_t [9:0] cfg;
        logic [31:0] prdata;
    } top_t;

    top_t r, n;

    logic [4:0] tb_tick;
    logic [9:0] ch_tick;
    logic [9:0] wave;
    pwm_pkg::chan_stat_t [9:0] stat;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic win_hit;
    logic [3:0] slot;
    logic [3:0] ofs;
    logic chan_slot;
    logic glob_slot;
    logic map_ok;
    logic acc_wr;
    logic setup_rd;
    logic [9:0] armed_vec;

    // the window compare maps registers only within the switch-set base; accesses outside it get an error response
    assign win_hit = (paddr[15:8] == board_window_base);
    assign slot = paddr[7:4];
    assign ofs = paddr[3:0];
    assign chan_slot = (slot < pwm_pkg::NUM_CHAN_SLOT);
    assign glob_slot = (slot == pwm_pkg::GLOBAL_SLOT);

    // every channel offset is mapped; the global slot holds three words
    always_comb begin
        map_ok = 1'b0;
        if (win_hit && chan_slot) begin
            map_ok = 1'b1;
        end else if (win_hit && glob_slot) begin
            map_ok = (ofs == pwm_pkg::OFS_ARM_SET) || (ofs == pwm_pkg::OFS_ARM_CLR)
                || (ofs == pwm_pkg::OFS_SUMMARY);
        end
    end

    // zero wait states: the access phase always completes in one cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !map_ok;
    assign acc_wr = psel && penable && pwrite && map_ok;
    assign setup_rd = psel && !penable && !pwrite;

    generate
        for (genvar i = 0; i < pwm_pkg::NUM_CHAN; i++) begin : g_armed
            assign armed_vec[i] = r.cfg[i].armed;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    // locks keep the fixed quantity of each mode constant while the channel runs
    always_comb begin
        n = r;
        if (acc_wr && chan_slot) begin
            for (int i = 0; i < pwm_pkg::NUM_CHAN; i++) begin
                if (slot == 4'(i)) begin
                    unique case (ofs)
                        pwm_pkg::OFS_CTRL: begin
                            // mode switching on a running channel would mix two waveforms
                            if (!r.cfg[i].armed) begin
                                n.cfg[i].mode = pwm_pkg::chan_mode_t'(pwdata[pwm_pkg::CTRL_MODE_BIT]);
                            end
                            n.cfg[i].toggle_high = pwdata[pwm_pkg::CTRL_TOGGLE_BIT];
                            n.cfg[i].armed = pwdata[pwm_pkg::CTRL_ARM_BIT];
                            n.cfg[i].base_sel = pwdata[pwm_pkg::CTRL_BASE_LSB +: 3];
                        end
                        pwm_pkg::OFS_PERIOD: begin
                            // pulse-width mode holds its period while armed
                            if (!(r.cfg[i].mode == pwm_pkg::MODE_PULSE_WIDTH && r.cfg[i].armed)) begin
                                n.cfg[i].period = pwdata[15:0];
                            end
                        end
                        pwm_pkg::OFS_DUTY: begin
                            // frequency mode holds its duty while armed
                            if (!(r.cfg[i].mode == pwm_pkg::frequency_mode && r.cfg[i].armed)) begin
                                n.cfg[i].duty = pwdata[15:0];
                            end
                        end
                        default: begin
                            // status is read-only
                        end
                    endcase
                end
            end
        end else if (acc_wr && glob_slot) begin
            // group arm and disarm let several channels start on the same edge
            for (int i = 0; i < pwm_pkg::NUM_CHAN; i++) begin
                if (ofs == pwm_pkg::OFS_ARM_SET && pwdata[i]) begin
                    n.cfg[i].armed = 1'b1;
                end
                if (ofs == pwm_pkg::OFS_ARM_CLR && pwdata[i]) begin
                    n.cfg[i].armed = 1'b0;
                end
            end
        end

        // read data is latched in the setup cycle so it comes from a flip-flop
        if (setup_rd) begin
            n.prdata = 32'h0000_0000;
            if (map_ok && chan_slot) begin
                for (int i = 0; i < pwm_pkg::NUM_CHAN; i++) begin
                    if (slot == 4'(i)) begin
                        unique case (ofs)
                            pwm_pkg::OFS_CTRL: begin
                                n.prdata[pwm_pkg::CTRL_MODE_BIT] = r.cfg[i].mode;
                                n.prdata[pwm_pkg::CTRL_TOGGLE_BIT] = r.cfg[i].toggle_high;
                                n.prdata[pwm_pkg::CTRL_ARM_BIT] = r.cfg[i].armed;
                                n.prdata[pwm_pkg::CTRL_BASE_LSB +: 3] = r.cfg[i].base_sel;
                            end
                            pwm_pkg::OFS_PERIOD: begin
                                n.prdata[15:0] = r.cfg[i].period;
                            end
                            pwm_pkg::OFS_DUTY: begin
                                n.prdata[15:0] = r.cfg[i].duty;
                            end
                            pwm_pkg::OFS_STATUS: begin
                                n.prdata[pwm_pkg::STAT_COUNT_LSB +: 16] = stat[i].count;
                                n.prdata[pwm_pkg::STAT_WAVE_BIT] = stat[i].wave;
                                n.prdata[pwm_pkg::STAT_ARMED_BIT] = r.cfg[i].armed;
                                n.prdata[pwm_pkg::STAT_PEND_BIT] = stat[i].pending;
                            end
                            default: begin
                                n.prdata = 32'h0000_0000;
                            end
                        endcase
                    end
                end
            end else if (map_ok && glob_slot && ofs == pwm_pkg::OFS_SUMMARY) begin
                n.prdata[pwm_pkg::SUM_ARMED_LSB +: 10] = armed_vec;
                n.prdata[pwm_pkg::SUM_WAVE_LSB +: 10] = wave;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // reset values are the initial settings each channel starts with
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < pwm_pkg::NUM_CHAN; i++) begin
                r.cfg[i].mode <= pwm_pkg::INIT_MODE;
                r.cfg[i].toggle_high <= pwm_pkg::INIT_TOGGLE;
                r.cfg[i].armed <= pwm_pkg::INIT_ARM[i];
                r.cfg[i].base_sel <= pwm_pkg::INIT_BASE;
                r.cfg[i].period <= pwm_pkg::INIT_PERIOD;
                r.cfg[i].duty <= pwm_pkg::INIT_DUTY;
            end
            r.prdata <= 32'h0000_0000;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;

    ////////////////////////////////////////////////////////////////////////////
    // timebase and channels

    timebase_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tb_tick)
    );

    // ten separate channels, each with its own timebase choice
    generate
        for (genvar i = 0; i < pwm_pkg::NUM_CHAN; i++) begin : g_chan
            // an unused source code stalls the channel rather than guessing a rate
            assign ch_tick[i] = (r.cfg[i].base_sel < 3'(pwm_pkg::NUM_SRC))
                ? tb_tick[r.cfg[i].base_sel] : 1'b0;

            counter_channel u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .tick(ch_tick[i]),
                .cfg(r.cfg[i]),
                .wave(wave[i]),
                .stat(stat[i])
            );
        end
    endgenerate

    // two groups of five, as two counter devices would present them
    assign group_a_out = wave[pwm_pkg::GROUP_SIZE-1:0];
    assign group_b_out = wave[pwm_pkg::NUM_CHAN-1:pwm_pkg::GROUP_SIZE];

endmodule // counter_pwm_fm_generator

// ---- src/timebase_prescaler.sv ----
// Purpose: derive the five timebase enables from pclk
// Assumes: pclk at 25 MHz
// Notes: chained decade dividers keep every counter short; all enables are one-cycle pulses
`timescale 1ns/1ps
module timebase_prescaler (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // enables, index 0 is the 1 MHz source
    output logic [4:0] tick
);

    typedef struct packed {
        logic [4:0] div;
        logic [3:0][3:0] dec;
        logic [4:0] tick;
    } pre_state_t;

    pre_state_t r, n;

    // each decade stage advances only on the stage below it
    always_comb begin
        n = r;
        n.tick = '0;
        n.div = (r.div == pwm_pkg::PRE_LAST) ? 5'h00 : r.div + 5'h01;
        n.tick[0] = (r.div == pwm_pkg::PRE_LAST);
        for (int k = 1; k < pwm_pkg::NUM_SRC; k++) begin
            if (n.tick[k-1]) begin
                if (r.dec[k-1] == pwm_pkg::DEC_LAST) begin
                    n.dec[k-1] = 4'h0;
                    n.tick[k] = 1'b1;
                end else begin
                    n.dec[k-1] = r.dec[k-1] + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;

endmodule // timebase_prescaler

// ---- verif/apb_host_model.sv ----
// Purpose: host processor that programs the generator over apb
// Assumes: pready is sampled only at rising edges
// Notes: one idle cycle between transfers keeps the task simple, back to back is not exercised
`timescale 1ns/1ps
module apb_host_model (
    // clock
    input wire logic pclk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [15:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
    end

    // one transfer; the caller paces duty updates at a fixed rate
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        // released lines show garbage
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // apb_host_model

// ---- verif/counter_pwm_fm_generator_assertions.sv ----
// Purpose: port-level checks for the pwm/fm generator
// Assumes: bound to the top module, single pclk domain
// Notes: wave edges of one channel are at least one 1 MHz tick apart unless a write caused them
`timescale 1ns/1ps
module counter_pwm_fm_generator_assertions (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // switches and waves
    input wire logic [7:0] board_window_base,
    input wire logic [4:0] group_a_out,
    input wire logic [4:0] group_b_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    logic acc;
    logic bad;
    logic [9:0] wv;
    logic [2:0] wr_q_r;
    assign acc = psel && penable;
    assign bad = paddr[15:8] != board_window_base || (paddr[7:4] > 4'h9 && paddr[7:4] < 4'hF)
        || (paddr[7:4] == 4'hF && paddr[3:2] == 2'h3);
    assign wv = {group_b_out, group_a_out};
    // a write may move a wave off the tick grid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wr_q_r <= 3'h0;
        else
            wr_q_r <= {wr_q_r[1:0], acc && pwrite};
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus checks
    chk_ready_high: assert property (pready)
        else $error("pready dropped");
    chk_err_unmapped: assert property (acc && bad |-> pslverr)
        else $error("unmapped access without error");
    chk_err_mapped: assert property (acc && !bad && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access flagged");
    chk_err_idle: assert property (!acc |-> !pslverr)
        else $error("error outside access phase");
    chk_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    chk_rdata_zero: assert property (psel && !penable && !pwrite && bad |=> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    ////////////////////////////////////////////////////////////////////////////
    // per-channel wave checks
    for (genvar i = 0; i < 10; i++) begin : g_ch
        chk_wave_grid: assert property ($changed(wv[i]) && wr_q_r == 3'h0 |=>
            ($stable(wv[i]) || wr_q_r != 3'h0) [*8])
            else $error("wave edges too close");
        chk_disarm_still: assert property (acc && pwrite && !bad && paddr[7:0] == 8'hF4 && pwdata[i]
            |-> ##4 ($stable(wv[i]) || wr_q_r != 3'h0) [*8])
            else $error("disarmed wave still moving");
    end

    cov_write: cover property (acc && pwrite && !bad);
    cov_refused: cover property (acc && bad);
    cov_wave: cover property ($changed(wv));
endmodule // counter_pwm_fm_generator_assertions

bind counter_pwm_fm_generator counter_pwm_fm_generator_assertions chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .board_window_base(board_window_base),
    .group_a_out(group_a_out), .group_b_out(group_b_out));

// ---- verif/counter_pwm_fm_generator_test.sv ----
// Purpose: self-checking bench for the ten-channel pwm/fm generator
// Assumes: host model drives apb, seed 81
// Notes: 1 kHz and 100 Hz bases are only read back, measuring them would take too long
`timescale 1ns/1ps
module counter_pwm_fm_generator_test;
    logic pclk;
    logic presetn;
    logic psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] board_window_base;
    logic [4:0] group_a_out, group_b_out;
    logic [9:0] wv, idle_lv;
    int num_errors = 0, cmp_count = 0;
    assign wv = {group_b_out, group_a_out};

    // 25 MHz clock
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    counter_pwm_fm_generator dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .board_window_base(board_window_base), .group_a_out(group_a_out),
        .group_b_out(group_b_out));
    apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] adr(input int s, input logic [3:0] o);
        return {board_window_base, 4'(s), o};
    endfunction
    function automatic logic [31:0] ctrl(input logic m, input logic t, input int b);
        return (32'(b) << 4) | (32'(t) << 1) | 32'(m);
    endfunction
    // active-level length in pclk cycles for a period and duty fraction
    function automatic int hi_cyc(input int p, input int d, input int b);
        return ((p * d) >> 16) * 25 * (10 ** b);
    endfunction
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] exp, input logic ee,
        input logic [31:0] msk = 32'hFFFF_FFFF);
        logic [31:0] q;
        logic e;
        host.xfer(1'b0, a, 32'h0000_0000, q, e);
        chk(nm, q & msk, exp);
        chk("err", 32'(e), 32'(ee));
    endtask
    task automatic wait_lvl(input int c, input logic lv, output int n);
        n = 0;
        while (wv[c] !== lv && n < 40000) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // watchdog well above the slowest measured run
    initial begin
        #3_000_000;
        num_errors++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int c, b, p, d, hi, lo;
        logic t;
        void'($urandom(81));
        presetn = 1'b0;
        board_window_base = 8'($urandom);
        idle_lv = 10'h000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // every channel leaves reset alike
        for (int i = 0; i < 10; i++) begin
            rd("ctrl", adr(i, pwm_pkg::OFS_CTRL), ctrl(1'b0, 1'b1, 1) | 32'h0000_0004, 1'b0);
            rd("period", adr(i, pwm_pkg::OFS_PERIOD), 32'h0000_000A, 1'b0);
            rd("duty", adr(i, pwm_pkg::OFS_DUTY), 32'h0000_4000, 1'b0);
        end
        rd("sum", adr(15, pwm_pkg::OFS_SUMMARY), 32'h0000_03FF, 1'b0, 32'h0000_03FF);
        // refused places answer with error and zero data
        rd("slot", adr(10 + $urandom % 5, 4'h0), 32'h0000_0000, 1'b1);
        rd("glob", adr(15, 4'hC), 32'h0000_0000, 1'b1);
        wr({~board_window_base, 8'h00}, 32'h0000_0000);
        rd("win", {~board_window_base, 8'h00}, 32'h0000_0000, 1'b1);
        rd("ctrl0", adr(0, pwm_pkg::OFS_CTRL), ctrl(1'b0, 1'b1, 1) | 32'h0000_0004, 1'b0);
        // slow bases are selectable too
        for (int k = 2; k < 5; k++) begin
            wr(adr(k, pwm_pkg::OFS_CTRL), ctrl(1'b0, 1'b1, k));
            rd("base", adr(k, pwm_pkg::OFS_CTRL), ctrl(1'b0, 1'b1, k), 1'b0);
        end
        wr(adr(15, pwm_pkg::OFS_ARM_CLR), 32'h0000_03FF);
        repeat (4) @(posedge pclk);
        chk("idle", 32'(wv), 32'h0000_0000);
        // two pulse-width and two frequency runs across three measured bases
        for (int i = 0; i < 4; i++) begin
            c = $urandom % 10;
            b = (i < 2) ? 0 : i - 1;
            t = 1'($urandom);
            p = 2 + $urandom % 3;
            d = 'h8000 | ($urandom & 'hFFFF);
            wr(adr(c, pwm_pkg::OFS_CTRL), ctrl(i[0], t, b));
            idle_lv[c] = ~t;
            wr(adr(c, pwm_pkg::OFS_PERIOD), 32'(p));
            wr(adr(c, pwm_pkg::OFS_DUTY), 32'(d));
            wr(adr(15, pwm_pkg::OFS_ARM_SET), 32'h0000_0001 << c);
            if (i[0]) begin
                // frequency mode: duty locked, period follows the host
                wr(adr(c, pwm_pkg::OFS_DUTY), 32'h0000_0001);
                rd("fm_duty", adr(c, pwm_pkg::OFS_DUTY), 32'(d), 1'b0);
                p = 2 + $urandom % 3;
                wr(adr(c, pwm_pkg::OFS_PERIOD), 32'(p));
                rd("fm_per", adr(c, pwm_pkg::OFS_PERIOD), 32'(p), 1'b0);
            end else begin
                // pulse-width mode: period locked, duty updated at a fixed pace
                wr(adr(c, pwm_pkg::OFS_PERIOD), 32'h0000_0007);
                rd("pw_per", adr(c, pwm_pkg::OFS_PERIOD), 32'(p), 1'b0);
                repeat (3) begin
                    d = 'h8000 | ($urandom & 'hFFFF);
                    repeat (40) @(posedge pclk);
                    wr(adr(c, pwm_pkg::OFS_DUTY), 32'(d));
                end
                rd("pw_duty", adr(c, pwm_pkg::OFS_DUTY), 32'(d), 1'b0);
            end
            wait_lvl(c, ~t, hi);
            wait_lvl(c, t, hi);
            wait_lvl(c, ~t, hi);
            wait_lvl(c, t, lo);
            chk("high", 32'(hi), 32'(hi_cyc(p, d, b)));
            chk("low", 32'(lo), 32'(p * 25 * (10 ** b) - hi_cyc(p, d, b)));
            chk("others", 32'((wv ^ idle_lv) & ~(10'h001 << c)), 32'h0000_0000);
            wr(adr(15, pwm_pkg::OFS_ARM_CLR), 32'h0000_0001 << c);
            repeat (4) @(posedge pclk);
            chk("disarm", 32'(wv), 32'(idle_lv));
            rd("stat", adr(c, pwm_pkg::OFS_STATUS), 32'(idle_lv[c]) << 16, 1'b0);
        end
        // second reset restores the armed start state
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd("sum2", adr(15, pwm_pkg::OFS_SUMMARY), 32'h0000_03FF, 1'b0, 32'h0000_03FF);
        final_report();
    end
endmodule // counter_pwm_fm_generator_test
